// file: hw/acq_scheduler.sv
// Base-cycle timer and interval counter for acquisition scheduling
`timescale 1ns/10ps
`default_nettype none
module acq_scheduler
  import touch_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = BASE_CYCLE_CYC
)
(
  input  wire logic  clock,
  input  wire logic  reset,
  input  wire logic  run,
  input  wire byte_t interval,
  output logic       due
);
  logic [31:0] base_r;
  logic [31:0] base_nxt;
  byte_t       count_r;
  byte_t       count_nxt;
  logic        tick;

  // Base cycle of about 16 ms
  always_comb
  begin
    tick = (base_r == BASE_CYCLES - 1);
    base_nxt = (!run || tick) ? 32'h0 : base_r + 32'h1;
    count_nxt = count_r;
    due = 1'b0;
    if (!run || interval == INTERVAL_SLEEP)
      count_nxt = 8'h00;
    else if (interval == INTERVAL_FREE)
      due = 1'b1;
    else if (tick)
    begin
      if (count_r + 8'h01 >= interval)
      begin
        due = 1'b1;
        count_nxt = 8'h00;
      end
      else
        count_nxt = count_r + 8'h01;
    end
  end

  // Registers only
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      base_r <= 32'h0;
      count_r <= 8'h00;
    end
    else
    begin
      base_r <= base_nxt;
      count_r <= count_nxt;
    end
  end
endmodule
`default_nettype wire

// file: hw/detect_filter.sv
// Per-key threshold and detect integrator with dominant-key group suppression
`timescale 1ns/10ps
`default_nettype none
module detect_filter
  import touch_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire byte_t      threshold [NUM_KEYS],
  input  wire byte_t      integrator_limit,
  input  wire key_vec_t   group_mask,
  key_bus_if.filter       kb
);
  byte_t    cnt_r [NUM_KEYS];
  byte_t    cnt_nxt [NUM_KEYS];
  key_vec_t raw_r;
  key_vec_t raw_nxt;
  key_vec_t det_r;
  key_vec_t det_nxt;
  key_vec_t over;
  int       winner;
  delta_t   best;

  // Threshold crossing, then integrate; release uses the fast integrator
  always_comb
  begin
    raw_nxt = raw_r;
    for (int k = 0; k < NUM_KEYS; k++)
    begin
      cnt_nxt[k] = cnt_r[k];
      over[k] = kb.enabled[k] && (kb.delta[k] >= {8'h00, threshold[k]});
      if (kb.calibrating || !kb.enabled[k])
      begin
        cnt_nxt[k] = 8'h00;
        raw_nxt[k] = 1'b0;
      end
      else if (kb.sample_valid)
      begin
        if (over[k] != raw_r[k])
        begin
          // Same count step whether or not another key is already in detect
          if (over[k] && (raw_r != 6'h00) && (cnt_r[k] + 8'h01 >= integrator_limit))
            cnt_nxt[k] = cnt_r[k] + 8'h01;
          else if (!over[k] || cnt_r[k] + 8'h01 < integrator_limit)
            cnt_nxt[k] = cnt_r[k] + 8'h01;
          if (!over[k])
          begin
            // Fast integrator ends a detection at once
            raw_nxt[k] = 1'b0;
            cnt_nxt[k] = 8'h00;
          end
          else if (cnt_r[k] + 8'h01 >= integrator_limit)
          begin
            raw_nxt[k] = 1'b1;
            cnt_nxt[k] = 8'h00;
          end
        end
        else
          cnt_nxt[k] = 8'h00;
      end
    end
  end

  // Largest delta in the group dominates, guards included
  always_comb
  begin
    winner = -1;
    best = 16'h0000;
    for (int k = 0; k < NUM_KEYS; k++)
      if (raw_nxt[k] && group_mask[k] && (winner < 0 || kb.delta[k] > best))
      begin
        winner = k;
        best = kb.delta[k];
      end
    for (int k = 0; k < NUM_KEYS; k++)
      det_nxt[k] = raw_nxt[k] && (!group_mask[k] || winner == k);
  end

  // Registers only
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      raw_r <= 6'h00;
      det_r <= 6'h00;
      for (int k = 0; k < NUM_KEYS; k++)
        cnt_r[k] <= 8'h00;
    end
    else
    begin
      raw_r <= raw_nxt;
      det_r <= det_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign kb.detect = det_r;
  // Integration in progress forces one-cycle interval
  always_comb
  begin
    kb.any_integrating = 1'b0;
    for (int k = 0; k < NUM_KEYS; k++)
      if (cnt_r[k] != 8'h00)
        kb.any_integrating = 1'b1;
  end
endmodule
`default_nettype wire

// file: hw/key_bus_if.sv
// Interface carrying per-key measurements into the detect filter
`timescale 1ns/10ps
`default_nettype none
interface key_bus_if;
  import touch_pkg::*;
  logic     sample_valid;
  delta_t   delta [NUM_KEYS];
  key_vec_t enabled;
  logic     calibrating;
  key_vec_t detect;
  logic     any_integrating;
  modport source (output sample_valid, output delta, output enabled, output calibrating,
                  input detect, input any_integrating);
  modport filter (input sample_valid, input delta, input enabled, input calibrating,
                  output detect, output any_integrating);
endinterface
`default_nettype wire

// file: hw/touch_acquisition_control.sv
// Top level: sequencer, calibration, status and change-notify line
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Acquisitions timed from a base cycle near 16 ms times the interval setting.
// - Interval zero sleeps: only a commanded calibration measures; detection status held, input status still follows the pins.
// - Interval 255 measures back to back, one idle clock apart, with no settle wait.
// - While calibrating or integrating, a nonzero interval is forced to one base cycle.
// - Group reports one touched key, the largest delta; others pushed out.
// - Group membership from group mask; other keys may detect together.
// - No automatic recalibration on long detect; host commands it.
// - Notify line low on status change, released when host reads status.
// - If status reverts before a read, line stays low until any read.
// - Only key-mask keys, input changes, start-up and calibration end assert the notify line.
// - Group key outside key mask is a silent guard suppressing others.
// - Nonzero reset byte write resets the device after about 16 ms.
// - After reset, slave address ignored for 30 ms.
// - 80 ms later assert notify, calibrate, assert notify again when done.
// - Nonzero calibration byte write starts a recalibration at any time.
// - Calibration checks burst length to enable or ignore each key.
// - Burst outside 16..1536 disables key until calibration; its signal reads zero.
// - Enabled-key count reported, updated after each calibration.
// - Touch needs threshold crossing held for a count, per-key threshold.
// - Programmable consecutive samples to detect; fast integrator ends detection.
// - No fast start when another key is already in detect; here any integration forces one base cycle regardless.
// - After waking from sleep or low power, wait 500 us before acquiring.
module touch_acquisition_control
  import touch_pkg::*;
#(
  parameter int unsigned BASE_CYCLES  = touch_pkg::BASE_CYCLE_CYC,
  parameter int unsigned SETTLE_CYCLES = touch_pkg::WAKE_SETTLE_CYC,
  parameter int unsigned SOFT_CYCLES  = touch_pkg::SOFT_RESET_CYC,
  parameter int unsigned NACK_CYCLES  = touch_pkg::INIT_NACK_CYC,
  parameter int unsigned READY_CYCLES = touch_pkg::READY_DELAY_CYC
)
(
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire touch_pkg::byte_t  interval_setting,
  input  wire touch_pkg::key_vec_t key_mask,
  input  wire touch_pkg::key_vec_t group_mask,
  input  wire touch_pkg::byte_t  threshold [touch_pkg::NUM_KEYS],
  input  wire touch_pkg::byte_t  integrator_limit,
  input  wire logic              reset_byte_write,
  input  wire touch_pkg::byte_t  reset_byte_data,
  input  wire logic              cal_byte_write,
  input  wire touch_pkg::byte_t  cal_byte_data,
  input  wire logic              status_read,
  input  wire logic              any_read,
  input  wire logic [6:0]        input_port_pins,
  output logic                   acquire_start,
  input  wire logic              acquire_done,
  input  wire touch_pkg::delta_t meas_delta [touch_pkg::NUM_KEYS],
  input  wire touch_pkg::burst_t meas_burst [touch_pkg::NUM_KEYS],
  output touch_pkg::key_vec_t    detection_status,
  output logic [6:0]             input_status,
  output logic [2:0]             enabled_key_count,
  output touch_pkg::key_vec_t    enabled_keys,
  output touch_pkg::delta_t      signal_value [touch_pkg::NUM_KEYS],
  output logic                   calibrating,
  output logic                   address_ack_enable,
  output logic                   change_notify_line_out,
  output logic                   change_notify_line_oe
);
  import touch_pkg::*;

  key_bus_if kb ();

  // Counts how many bits of a key vector are set
  function automatic logic [2:0] popcount(input key_vec_t v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < NUM_KEYS; i++)
      n = n + {2'b00, v[i]};
    return n;
  endfunction

  seq_state_t  state_r;
  seq_state_t  state_nxt;
  logic [31:0] timer_r;
  logic [31:0] timer_nxt;
  logic        cal_r;
  logic        cal_nxt;
  logic        cal_pending_r;
  logic        cal_pending_nxt;
  key_vec_t    en_r;
  key_vec_t    en_nxt;
  logic [2:0]  count_r;
  logic [2:0]  count_nxt;
  logic        notify_r;
  logic        notify_nxt;
  key_vec_t    det_snap_r;
  key_vec_t    det_snap_nxt;
  logic [6:0]  in_snap_r;
  logic [6:0]  in_snap_nxt;
  logic [6:0]  pin_meta_r;
  logic [6:0]  pin_sync_r;
  logic        sample_r;
  logic        sample_nxt;
  logic        asleep_r;
  logic        asleep_nxt;
  delta_t      sig_r [NUM_KEYS];
  delta_t      sig_nxt [NUM_KEYS];
  byte_t       eff_interval;
  logic        due;
  logic        run;
  logic        cal_cmd;

  // Pin inputs pass two flops before use
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pin_meta_r <= 7'h00;
      pin_sync_r <= 7'h00;
    end
    else
    begin
      pin_meta_r <= input_port_pins;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Forced single base cycle keeps calibration and integration responsive
  always_comb
  begin
    if (interval_setting != INTERVAL_SLEEP && (cal_r || kb.any_integrating))
      eff_interval = INTERVAL_ONE;
    else
      eff_interval = interval_setting;
  end

  assign run = (state_r == ST_IDLE);

  acq_scheduler #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_sched (
    .clock    (clock),
    .reset    (reset),
    .run      (run),
    .interval (eff_interval),
    .due      (due)
  );

  assign kb.sample_valid = sample_r;
  assign kb.enabled      = en_r;
  assign kb.calibrating  = cal_r;
  always_comb
  begin
    for (int k = 0; k < NUM_KEYS; k++)
      kb.delta[k] = sig_r[k];
  end

  detect_filter u_filter (
    .clock            (clock),
    .reset            (reset),
    .threshold        (threshold),
    .integrator_limit (integrator_limit),
    .group_mask       (group_mask),
    .kb               (kb)
  );

  assign cal_cmd = cal_byte_write && (cal_byte_data != 8'h00);

  // Sequencer: reset wait, init window, ready delay, then acquisition loop
  always_comb
  begin
    state_nxt = state_r;
    timer_nxt = timer_r + 32'h1;
    cal_nxt = cal_r;
    cal_pending_nxt = cal_pending_r || cal_cmd;
    en_nxt = en_r;
    count_nxt = count_r;
    sample_nxt = 1'b0;
    asleep_nxt = asleep_r;
    notify_nxt = notify_r;
    acquire_start = 1'b0;
    for (int k = 0; k < NUM_KEYS; k++)
      sig_nxt[k] = sig_r[k];
    case (state_r)
      ST_RESET_WAIT:
      begin
        state_nxt = ST_INIT_NACK;
        timer_nxt = 32'h0;
      end
      ST_INIT_NACK:
        if (timer_r >= NACK_CYCLES - 1)
        begin
          state_nxt = ST_READY_WAIT;
          timer_nxt = 32'h0;
        end
      ST_READY_WAIT:
        if (timer_r >= READY_CYCLES - 1)
        begin
          notify_nxt = 1'b1;
          cal_pending_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      ST_IDLE:
        if (cal_pending_r || due)
        begin
          // Calibration is always acquired promptly, even asleep
          if (cal_pending_r)
          begin
            cal_nxt = 1'b1;
            cal_pending_nxt = cal_cmd;
          end
          state_nxt = (asleep_r || interval_setting != INTERVAL_FREE) ? ST_SETTLE : ST_ACQUIRE;
          timer_nxt = 32'h0;
        end
        else if (interval_setting == INTERVAL_SLEEP)
          asleep_nxt = 1'b1;
      ST_SETTLE:
        if (timer_r >= SETTLE_CYCLES - 1)
        begin
          asleep_nxt = 1'b0;
          state_nxt = ST_ACQUIRE;
          acquire_start = 1'b1;
        end
      ST_ACQUIRE:
        if (acquire_done)
        begin
          state_nxt = ST_IDLE;
          for (int k = 0; k < NUM_KEYS; k++)
          begin
            if (cal_r)
              en_nxt[k] = (meas_burst[k] >= BURST_MIN) && (meas_burst[k] <= BURST_MAX);
            sig_nxt[k] = (cal_r ? en_nxt[k] : en_r[k]) ? meas_delta[k] : 16'h0000;
          end
          if (cal_r)
          begin
            count_nxt = popcount(en_nxt);
            cal_nxt = 1'b0;
            notify_nxt = 1'b1;
          end
          else
            sample_nxt = 1'b1;
        end
        else if (timer_r == 32'h0)
          acquire_start = 1'b1;
      ST_SOFT_RESET:
        if (timer_r >= SOFT_CYCLES - 1)
        begin
          state_nxt = ST_RESET_WAIT;
          cal_nxt = 1'b0;
          cal_pending_nxt = 1'b0;
          en_nxt = KEY_MASK_RESET;
          count_nxt = 3'h0;
          asleep_nxt = 1'b0;
          for (int k = 0; k < NUM_KEYS; k++)
            sig_nxt[k] = 16'h0000;
        end
      default:
        state_nxt = ST_RESET_WAIT;
    endcase
    if (reset_byte_write && reset_byte_data != 8'h00 && state_r != ST_SOFT_RESET)
    begin
      state_nxt = ST_SOFT_RESET;
      timer_nxt = 32'h0;
    end
    // Change of masked detection or inputs since the snapshot; set wins over any_read, but a status_read in the same cycle clears
    if (((kb.detect & key_mask) != (det_snap_nxt & key_mask)) || (pin_sync_r != in_snap_nxt))
      notify_nxt = 1'b1;
    else if (status_read || any_read)
      notify_nxt = 1'b0;
  end

  // Snapshots hold what the host last saw; reverted changes keep the line low
  always_comb
  begin
    det_snap_nxt = det_snap_r;
    in_snap_nxt = in_snap_r;
    if (status_read)
    begin
      det_snap_nxt = kb.detect;
      in_snap_nxt = pin_sync_r;
    end
  end

  // Registers only
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_r <= ST_RESET_WAIT;
      timer_r <= 32'h0;
      cal_r <= 1'b0;
      cal_pending_r <= 1'b0;
      en_r <= KEY_MASK_RESET;
      count_r <= 3'h0;
      notify_r <= 1'b0;
      det_snap_r <= 6'h00;
      in_snap_r <= 7'h00;
      sample_r <= 1'b0;
      asleep_r <= 1'b0;
      for (int k = 0; k < NUM_KEYS; k++)
        sig_r[k] <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
      cal_r <= cal_nxt;
      cal_pending_r <= cal_pending_nxt;
      en_r <= en_nxt;
      count_r <= count_nxt;
      notify_r <= notify_nxt;
      det_snap_r <= det_snap_nxt;
      in_snap_r <= in_snap_nxt;
      sample_r <= sample_nxt;
      asleep_r <= asleep_nxt;
      sig_r <= sig_nxt;
    end
  end

  // Outputs; no automatic recalibration on long detection
  assign detection_status       = kb.detect;
  assign input_status           = pin_sync_r;
  assign enabled_key_count      = count_r;
  assign enabled_keys           = en_r;
  assign signal_value           = sig_r;
  assign calibrating            = cal_r;
  assign address_ack_enable     = (state_r != ST_RESET_WAIT) && (state_r != ST_INIT_NACK)
                                  && (state_r != ST_SOFT_RESET);
  assign change_notify_line_out = 1'b0;
  assign change_notify_line_oe  = notify_r;
endmodule
`default_nettype wire

// file: hw/touch_pkg.sv
// Package with constants and types for the touch acquisition controller
package touch_pkg;
  localparam int unsigned CLOCK_HZ        = 250_000_000;
  localparam int unsigned NUM_KEYS        = 6;
  localparam int unsigned BASE_CYCLE_US   = 16_000;
  localparam int unsigned WAKE_SETTLE_US  = 500;
  localparam int unsigned SOFT_RESET_US   = 16_000;
  localparam int unsigned INIT_NACK_US    = 30_000;
  localparam int unsigned READY_DELAY_US  = 80_000;
  localparam int unsigned CYC_PER_US      = CLOCK_HZ / 1_000_000;
  localparam int unsigned BASE_CYCLE_CYC  = BASE_CYCLE_US * CYC_PER_US;
  localparam int unsigned WAKE_SETTLE_CYC = WAKE_SETTLE_US * CYC_PER_US;
  localparam int unsigned SOFT_RESET_CYC  = SOFT_RESET_US * CYC_PER_US;
  localparam int unsigned INIT_NACK_CYC   = INIT_NACK_US * CYC_PER_US;
  localparam int unsigned READY_DELAY_CYC = READY_DELAY_US * CYC_PER_US;
  localparam logic [7:0]  INTERVAL_SLEEP  = 8'h00;
  localparam logic [7:0]  INTERVAL_ONE    = 8'h01;
  localparam logic [7:0]  INTERVAL_FREE   = 8'hff;
  localparam logic [7:0]  INTERVAL_RESET  = 8'h02;
  localparam logic [10:0] BURST_MIN       = 11'h010;
  localparam logic [10:0] BURST_MAX       = 11'h600;
  localparam logic [7:0]  INTEGRATOR_RESET = 8'h04;
  localparam logic [5:0]  KEY_MASK_RESET  = 6'h3f;
  localparam logic [5:0]  GROUP_MASK_RESET = 6'h00;
  localparam logic [7:0]  THRESHOLD_RESET = 8'h0a;

  typedef logic [5:0]  key_vec_t;
  typedef logic [15:0] delta_t;
  typedef logic [10:0] burst_t;
  typedef logic [7:0]  byte_t;

  typedef enum logic [2:0]
  {
    ST_RESET_WAIT = 3'b000,
    ST_INIT_NACK  = 3'b001,
    ST_READY_WAIT = 3'b010,
    ST_IDLE       = 3'b011,
    ST_SETTLE     = 3'b100,
    ST_ACQUIRE    = 3'b101,
    ST_SOFT_RESET = 3'b110
  } seq_state_t;
endpackage

// file: test/sense_front_model.sv
// Behavioural sense front end answering acquisition requests
`timescale 1ns/10ps
`default_nettype none
module sense_front_model
  import touch_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   reset,
  input  wire logic   slow,
  input  wire logic   acquire_start,
  input  wire delta_t delta_in [NUM_KEYS],
  input  wire burst_t burst_in [NUM_KEYS],
  output logic        acquire_done,
  output delta_t      meas_delta [NUM_KEYS],
  output burst_t      meas_burst [NUM_KEYS]
);
  int unsigned cnt_r;
  // Burst countdown, long when slow; a new request restarts it
  always_ff @(posedge clock)
  begin
    if (reset)
      cnt_r <= 0;
    else if (acquire_start)
      cnt_r <= slow ? 12 : 3;
    else if (cnt_r != 0)
      cnt_r <= cnt_r - 1;
  end
  assign acquire_done = (cnt_r == 1);
  // Inverted outside done so stale data never passes
  always_comb
  begin
    for (int k = 0; k < NUM_KEYS; k++)
    begin
      meas_delta[k] = acquire_done ? delta_in[k] : ~delta_in[k];
      meas_burst[k] = acquire_done ? burst_in[k] : ~burst_in[k];
    end
  end
endmodule
`default_nettype wire

// file: test/touch_acquisition_control_assertions.sv
// Port-level checks on the touch acquisition controller
`timescale 1ns/10ps
`default_nettype none
module touch_acquisition_control_assertions
  import touch_pkg::*;
#(
  parameter int unsigned NACK_CYCLES  = 30,
  parameter int unsigned READY_CYCLES = 40
)
(
  input wire logic     clock,
  input wire logic     reset,
  input wire byte_t    interval_setting,
  input wire key_vec_t group_mask,
  input wire logic     reset_byte_write,
  input wire byte_t    reset_byte_data,
  input wire logic     status_read,
  input wire logic     any_read,
  input wire logic     acquire_start,
  input wire logic     acquire_done,
  input wire key_vec_t detection_status,
  input wire key_vec_t enabled_keys,
  input wire delta_t   signal_value [NUM_KEYS],
  input wire logic     calibrating,
  input wire logic     address_ack_enable,
  input wire logic     change_notify_line_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  int unsigned since_r;
  logic        zero_ok;
  // Saturating cycles since reset release; times start-up only
  always_ff @(posedge clock)
    since_r <= reset ? 0 : since_r + 32'(since_r < 1000);
  // Disabled keys read zero
  always_comb
  begin
    zero_ok = 1'b1;
    for (int k = 0; k < NUM_KEYS; k++)
      if (!enabled_keys[k] && signal_value[k] != 16'h0)
        zero_ok = 1'b0;
  end
  AST_INIT_NACK: assert property (since_r < NACK_CYCLES |-> !address_ack_enable)
    else $error("ack in init");
  AST_ACK_BACK: assert property (since_r == NACK_CYCLES + 4 |-> address_ack_enable)
    else $error("no ack after init");
  AST_READY_QUIET: assert property (since_r < NACK_CYCLES + READY_CYCLES |-> !change_notify_line_oe)
    else $error("early notify");
  AST_READY_NOTIFY: assert property (since_r == NACK_CYCLES + READY_CYCLES + 1 |-> change_notify_line_oe)
    else $error("no ready notify");
  AST_NOTIFY_HOLD: assert property (change_notify_line_oe && address_ack_enable && !status_read && !any_read
    && !reset_byte_write |=> change_notify_line_oe)
    else $error("notify dropped");
  AST_SOFT_DROP: assert property (reset_byte_write && reset_byte_data != 8'h00 && address_ack_enable
    |=> !address_ack_enable [*8])
    else $error("ack in soft reset");
  AST_ZERO_IGNORED: assert property (reset_byte_write && reset_byte_data == 8'h00 && address_ack_enable
    |=> address_ack_enable)
    else $error("zero reset byte used");
  AST_SIGNAL_ZERO: assert property ($stable(enabled_keys) |-> zero_ok)
    else $error("disabled signal nonzero");
  AST_GROUP_ONE: assert property ($stable(group_mask) |-> $onehot0(detection_status & group_mask))
    else $error("two group keys");
  AST_WAKE_SETTLE: assert property ($past(interval_setting) == 8'h00 && interval_setting != 8'h00
    |-> !acquire_start [*8])
    else $error("no wake settle");
  AST_FREE_RUN: assert property (interval_setting == 8'hff && acquire_done && !calibrating
    |-> ##[1:16] acquire_start)
    else $error("free-run gap");
  AST_START_PULSE: assert property (acquire_start |=> !acquire_start)
    else $error("long start");
  COV_FREE: cover property (interval_setting == 8'hff && acquire_done);
  COV_GROUP: cover property (group_mask != 6'h00 && detection_status != 6'h00);
  COV_SOFT: cover property ($fell(address_ack_enable));
endmodule
bind touch_acquisition_control touch_acquisition_control_assertions
  #(.NACK_CYCLES(NACK_CYCLES), .READY_CYCLES(READY_CYCLES)) u_chk
(
  .clock, .reset, .interval_setting, .group_mask, .reset_byte_write, .reset_byte_data,
  .status_read, .any_read, .acquire_start, .acquire_done, .detection_status, .enabled_keys,
  .signal_value, .calibrating, .address_ack_enable, .change_notify_line_oe
);
`default_nettype wire

// file: test/touch_acquisition_control_test.sv
// Scenario testbench for the touch acquisition controller
`timescale 1ns/10ps
`default_nettype none
module touch_acquisition_control_test;
  import touch_pkg::*;
  localparam int BASE = 100;
  localparam int SETTLE = 10;
  localparam int SOFT = 20;
  localparam int NACK = 30;
  localparam int READY = 40;
  logic clock = 1'b0, reset = 1'b1, slow = 1'b0;
  byte_t interval_setting = INTERVAL_ONE, integrator_limit = 8'h01;
  key_vec_t key_mask = 6'h3f, group_mask = 6'h00;
  byte_t threshold [NUM_KEYS] = '{default: 8'h0a};
  logic reset_byte_write = 1'b0, cal_byte_write = 1'b0, status_read = 1'b0, any_read = 1'b0;
  byte_t reset_byte_data = 8'h00, cal_byte_data = 8'h00;
  logic [6:0] input_port_pins = 7'h00, input_status;
  delta_t delta_in [NUM_KEYS] = '{5: 16'h33, default: 16'h0};
  burst_t burst_in [NUM_KEYS] = '{11'h010, 11'h600, 11'h100, 11'h100, 11'h601, 11'h00f};
  logic acquire_start, acquire_done, calibrating, ack, cn_out, oe;
  delta_t meas_delta [NUM_KEYS], signal_value [NUM_KEYS];
  burst_t meas_burst [NUM_KEYS];
  key_vec_t det, enabled_keys;
  logic [2:0] enabled_key_count;
  int n_fail = 0, n_checks = 0, n;
  always #2 clock = ~clock;
  touch_acquisition_control #(.BASE_CYCLES(BASE), .SETTLE_CYCLES(SETTLE), .SOFT_CYCLES(SOFT),
    .NACK_CYCLES(NACK), .READY_CYCLES(READY)) DUT
  (
    .clock, .reset, .interval_setting, .key_mask, .group_mask, .threshold, .integrator_limit,
    .reset_byte_write, .reset_byte_data, .cal_byte_write, .cal_byte_data, .status_read, .any_read,
    .input_port_pins, .acquire_start, .acquire_done, .meas_delta, .meas_burst, .detection_status(det),
    .input_status, .enabled_key_count, .enabled_keys, .signal_value, .calibrating,
    .address_ack_enable(ack), .change_notify_line_out(cn_out), .change_notify_line_oe(oe)
  );
  sense_front_model u_front
  (
    .clock, .reset, .slow, .acquire_start, .delta_in, .burst_in, .acquire_done, .meas_delta, .meas_burst
  );
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait at falling edges, counted in n; timeout ends the run
  task automatic wait_lvl(ref logic s, input logic v);
    n = 0;
    while (s !== v)
    begin
      @(negedge clock);
      n++;
      if (n > 2000)
      begin
        chk(16'(s), 16'(v));
        tally_and_finish();
      end
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask
  // One acquisition: detect lands two cycles after done
  task automatic acq();
    wait_lvl(acquire_done, 1'b1);
    repeat (3) @(negedge clock);
  endtask
  task automatic t_start();
    chk(16'(ack), 16'h0);
    wait_lvl(oe, 1'b1);
    chk(16'(ack), 16'h1);
    wait_lvl(calibrating, 1'b1);
    pulse(status_read);
    chk(16'(oe), 16'h0);
    wait_lvl(calibrating, 1'b0);
    repeat (2) @(negedge clock);
    chk(16'(oe), 16'h1);
    chk(16'(enabled_keys), 16'hf);
    chk(16'(enabled_key_count), 16'h4);
    chk(signal_value[5], 16'h0);
    pulse(status_read);
  endtask
  task automatic t_detect();
    integrator_limit = 8'h02;
    delta_in[0] = 16'h9;
    acq();
    chk(16'(det), 16'h0);
    delta_in[0] = 16'ha;
    acq();
    chk(16'(det), 16'h0);
    acq();
    chk(16'(det), 16'h1);
    chk(16'(oe), 16'h1);
    pulse(status_read);
    chk(16'(oe), 16'h0);
    delta_in[0] = 16'h0;
    acq();
    chk(16'(det), 16'h0);
    pulse(status_read);
    integrator_limit = 8'h01;
  endtask
  // Touch then release before a read keeps the line low
  task automatic t_revert();
    delta_in[1] = 16'h20;
    acq();
    delta_in[1] = 16'h0;
    acq();
    chk(16'(oe), 16'h1);
    pulse(any_read);
    chk(16'(oe), 16'h0);
  endtask
  // Key 2 is a guard: in the group, out of the key mask
  task automatic t_group();
    key_mask = 6'h3b;
    group_mask = 6'h07;
    delta_in[2] = 16'h50;
    acq();
    chk(16'(oe), 16'h0);
    delta_in[0] = 16'h20;
    delta_in[1] = 16'h30;
    delta_in[3] = 16'h40;
    acq();
    chk(16'(det & 6'h3b), 16'h8);
    delta_in[2] = 16'h0;
    acq();
    chk(16'(det), 16'ha);
    delta_in = '{default: 16'h0};
    acq();
    pulse(status_read);
    key_mask = 6'h3f;
    input_port_pins = 7'h55;
    wait_lvl(oe, 1'b1);
    chk(16'(input_status), 16'h55);
    pulse(status_read);
  endtask
  task automatic t_sleep();
    int k = 0;
    delta_in[3] = 16'h40;
    acq();
    pulse(status_read);
    interval_setting = INTERVAL_SLEEP;
    delta_in[3] = 16'h0;
    for (int i = 0; i < 400; i++)
    begin
      @(negedge clock);
      k += int'(acquire_start);
    end
    chk(16'(k), 16'h0);
    chk(16'(det), 16'h8);
    interval_setting = INTERVAL_ONE;
    wait_lvl(acquire_start, 1'b1);
    chk(16'(n >= SETTLE), 16'h1);
    acq();
    chk(16'(det), 16'h0);
    pulse(status_read);
  endtask
  // Start spacing for several intervals, then free run
  task automatic t_interval();
    for (int iv = 1; iv <= 4; iv++)
    begin
      interval_setting = (iv == 4) ? INTERVAL_FREE : 8'(iv);
      wait_lvl(acquire_start, 1'b1);
      @(negedge clock);
      wait_lvl(acquire_start, 1'b1);
      if (iv == 4)
        chk(16'(n <= 8), 16'h1);
      else
        chk(16'(n >= iv * BASE - 2 && n <= iv * BASE + SETTLE + 20), 16'h1);
    end
  endtask
  task automatic t_cal();
    interval_setting = 8'h03;
    burst_in[5] = 11'h100;
    slow = 1'b1;
    pulse(cal_byte_write);
    repeat (4) @(negedge clock);
    chk(16'(calibrating), 16'h0);
    cal_byte_data = 8'h5a;
    pulse(cal_byte_write);
    wait_lvl(acquire_start, 1'b1);
    chk(16'(n <= BASE + SETTLE + 20), 16'h1);
    wait_lvl(calibrating, 1'b0);
    repeat (2) @(negedge clock);
    chk(16'(enabled_keys), 16'h2f);
    chk(16'(enabled_key_count), 16'h5);
    slow = 1'b0;
  endtask
  task automatic t_soft();
    pulse(status_read);
    pulse(reset_byte_write);
    chk(16'(ack), 16'h1);
    reset_byte_data = 8'h01;
    pulse(reset_byte_write);
    chk(16'(ack), 16'h0);
    wait_lvl(ack, 1'b1);
    chk(16'(n >= SOFT + NACK && n <= SOFT + NACK + 6), 16'h1);
    wait_lvl(oe, 1'b1);
    chk(16'(n >= READY && n <= READY + 6), 16'h1);
  endtask
  initial
  begin
    repeat (8) @(negedge clock);
    reset = 1'b0;
    t_start();
    t_detect();
    t_revert();
    t_group();
    t_sleep();
    t_interval();
    t_cal();
    t_soft();
    tally_and_finish();
  end
endmodule
`default_nettype wire
